/* logic/iass_params.svh */
// Constants for the acknowledge/stop sequencer: register map and fields.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef IASS_PARAMS_SVH
`define IASS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IASS_CTRL_OFF 12'h000
`define IASS_STAT_OFF 12'h004
`define IASS_RELOAD_OFF 12'h008
`define IASS_TXBUF_OFF 12'h00c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IASS_CTRL_ACK_SEQ_ENABLE_BIT 0
`define IASS_CTRL_STOPEN_BIT 1
`define IASS_CTRL_ACK_DATA_VALUE_BIT 2
`define IASS_STAT_STOPDET_BIT 0
`define IASS_STAT_IRQ_BIT 1
`define IASS_STAT_WRITE_COLLISION_FLAG_BIT 2
`define IASS_STAT_BCOL_BIT 3
`define IASS_STAT_BUSY_BIT 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IASS_RELOAD_RST 8'h09
`define IASS_TXBUF_RST 8'h00

`endif

/* logic/iass_pkg.sv */
// Types shared by the acknowledge/stop sequencer.
// Assumes nothing beyond the params header.
package iass_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        IASS_IDLE = 4'b0000,
        IASS_ACK_LOW = 4'b0001,
        IASS_ACK_WAIT_HI = 4'b0010,
        IASS_ACK_HIGH = 4'b0011,
        IASS_STP_DLOW = 4'b0100,
        IASS_STP_CLOW = 4'b0101,
        IASS_STP_WAIT_HI = 4'b0110,
        IASS_STP_CHIGH = 4'b0111,
        IASS_STP_DHIGH = 4'b1000,
        IASS_STP_TAIL = 4'b1001
    } iass_state_t;

    // Open-drain pin: level seen, drive low when oe is high
    typedef struct packed {
        logic clk_oe;
        logic dat_oe;
    } iass_drive_t;

    typedef struct packed {
        logic clk_in;
        logic dat_in;
    } iass_sense_t;

endpackage

/* logic/iass_seq.sv */
// Two-wire master sequencer for the acknowledge bit and the Stop condition.
// Assumes APB on pclk, bus pins already synchronous to pclk, pulled up.
// What this block does
// - Setting ack enable pulls clock low, drives stored ack data value.
// - Ack data zero drives low (ACK), one releases high (NACK).
// - After one rollover period the clock line is released high.
// - Clock sampled high, another rollover period, then clock pulled low.
// - Ack end clears ack enable, stops generator, returns to idle.
// - Buffer write during ack sequence is dropped and sets write collision.
// - Clock held low; setting stop enable drives data line low.
// - Data sampled low in Stop reloads generator, counts down to zero.
// - On timeout release clock, then release data one period later.
// - Data high while clock high sets stop-detected flag.
// - One period after stop detect, clear stop enable, set irq flag.
// - Buffer write during Stop is dropped and sets write collision.
// - Clock sampled high in Stop loads generator from reload, counts down.
// - Data low after timeout following its release flags bus collision.
// - Clock low after release, before data floats, flags bus collision.
`include "iass_params.svh"

module iass_seq #(
    parameter int RW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iass_pkg::iass_sense_t bus_sense,
    output iass_pkg::iass_drive_t bus_drive
);
    import iass_pkg::*;

    // ------------------------------------------------------------------
    // Bus slave decode
    // ------------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic hit;
    assign hit = (paddr == `IASS_CTRL_OFF) || (paddr == `IASS_STAT_OFF) ||
                 (paddr == `IASS_RELOAD_OFF) || (paddr == `IASS_TXBUF_OFF);
    assign wr_en = psel && penable && pwrite && hit;
    assign rd_en = psel && penable && !pwrite;
    // Zero wait states keeps the slave simple; every access ends at once
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    iass_state_t state_q;
    logic ack_en_q;
    logic stop_en_q;
    logic ack_dt_q;
    logic stop_det_q;
    logic irq_q;
    logic write_collision_flag_q;
    logic bcol_q;
    logic clk_hold_q;
    logic [RW-1:0] reload_q;
    logic [7:0] txbuf_q;
    logic [RW-1:0] brg_q;
    logic brg_run_q;
    logic brg_load;
    logic brg_tout;
    logic busy;
    logic clk_hi;
    logic dat_hi;

    assign clk_hi = bus_sense.clk_in;
    assign dat_hi = bus_sense.dat_in;
    assign busy = (state_q != IASS_IDLE);
    assign brg_tout = brg_run_q && (brg_q == '0);

    logic wr_ctrl;
    logic wr_stat;
    logic wr_buf;
    assign wr_ctrl = wr_en && (paddr == `IASS_CTRL_OFF);
    assign wr_stat = wr_en && (paddr == `IASS_STAT_OFF);
    assign wr_buf = wr_en && (paddr == `IASS_TXBUF_OFF);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    iass_state_t state_d;
    logic bcol_ev;
    logic done_ack;
    logic done_stop;
    logic stop_seen;

    always_comb begin
        state_d = state_q;
        brg_load = 1'b0;
        bcol_ev = 1'b0;
        done_ack = 1'b0;
        done_stop = 1'b0;
        stop_seen = 1'b0;
        unique case (state_q)
            IASS_IDLE: begin
                if (wr_ctrl && pwdata[`IASS_CTRL_ACK_SEQ_ENABLE_BIT]) begin
                    state_d = IASS_ACK_LOW;
                    brg_load = 1'b1;
                end else if (wr_ctrl && pwdata[`IASS_CTRL_STOPEN_BIT]) begin
                    state_d = IASS_STP_DLOW;
                end
            end
            IASS_ACK_LOW: begin
                if (brg_tout) begin
                    state_d = IASS_ACK_WAIT_HI;
                end
            end
            IASS_ACK_WAIT_HI: begin
                // Slave may stretch; wait for the real high level
                if (clk_hi) begin
                    state_d = IASS_ACK_HIGH;
                    brg_load = 1'b1;
                end
            end
            IASS_ACK_HIGH: begin
                if (brg_tout) begin
                    state_d = IASS_IDLE;
                    done_ack = 1'b1;
                end
            end
            IASS_STP_DLOW: begin
                if (!dat_hi) begin
                    state_d = IASS_STP_CLOW;
                    brg_load = 1'b1;
                end
            end
            IASS_STP_CLOW: begin
                if (brg_tout) begin
                    state_d = IASS_STP_WAIT_HI;
                end
            end
            IASS_STP_WAIT_HI: begin
                if (clk_hi) begin
                    state_d = IASS_STP_CHIGH;
                    brg_load = 1'b1;
                end
            end
            IASS_STP_CHIGH: begin
                if (!clk_hi) begin
                    bcol_ev = 1'b1;
                    state_d = IASS_IDLE;
                end else if (brg_tout) begin
                    state_d = IASS_STP_DHIGH;
                    brg_load = 1'b1;
                end
            end
            IASS_STP_DHIGH: begin
                // Data released; it must read high once the period is up
                if (brg_tout) begin
                    if (!dat_hi) begin
                        bcol_ev = 1'b1;
                        state_d = IASS_IDLE;
                    end else if (clk_hi) begin
                        stop_seen = 1'b1;
                        state_d = IASS_STP_TAIL;
                        brg_load = 1'b1;
                    end
                end
            end
            IASS_STP_TAIL: begin
                if (brg_tout) begin
                    state_d = IASS_IDLE;
                    done_stop = 1'b1;
                end
            end
            default: begin
                state_d = IASS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= IASS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Clock stays low after an ack so a Stop can follow the ninth clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_hold_q <= 1'b0;
        end else if (done_ack) begin
            clk_hold_q <= 1'b1;
        end else if (state_d != IASS_IDLE || bcol_ev) begin
            clk_hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Baud rate generator
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brg_q <= '0;
            brg_run_q <= 1'b0;
        end else if (brg_load) begin
            brg_q <= reload_q;
            brg_run_q <= 1'b1;
        end else if (state_d == IASS_IDLE) begin
            brg_run_q <= 1'b0;
            brg_q <= '0;
        end else if (brg_run_q && brg_q != '0) begin
            brg_q <= brg_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive: oe high pulls the line low
    // ------------------------------------------------------------------
    always_comb begin
        bus_drive.clk_oe = 1'b0;
        bus_drive.dat_oe = 1'b0;
        unique case (state_q)
            IASS_IDLE: begin
                bus_drive.clk_oe = clk_hold_q;
            end
            IASS_ACK_LOW: begin
                bus_drive.clk_oe = 1'b1;
                bus_drive.dat_oe = !ack_dt_q;
            end
            IASS_ACK_WAIT_HI, IASS_ACK_HIGH: begin
                bus_drive.dat_oe = !ack_dt_q;
            end
            IASS_STP_DLOW, IASS_STP_CLOW: begin
                bus_drive.clk_oe = 1'b1;
                bus_drive.dat_oe = 1'b1;
            end
            IASS_STP_WAIT_HI, IASS_STP_CHIGH: begin
                bus_drive.dat_oe = 1'b1;
            end
            default: begin
                bus_drive.clk_oe = 1'b0;
                bus_drive.dat_oe = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_en_q <= 1'b0;
            stop_en_q <= 1'b0;
            ack_dt_q <= 1'b0;
        end else begin
            if (wr_ctrl && !busy) begin
                ack_dt_q <= pwdata[`IASS_CTRL_ACK_DATA_VALUE_BIT];
            end
            if (state_d == IASS_IDLE) begin
                ack_en_q <= 1'b0;
                stop_en_q <= 1'b0;
            end else begin
                ack_en_q <= (state_d inside {IASS_ACK_LOW, IASS_ACK_WAIT_HI,
                                             IASS_ACK_HIGH});
                stop_en_q <= !(state_d inside {IASS_ACK_LOW,
                                               IASS_ACK_WAIT_HI,
                                               IASS_ACK_HIGH});
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags: set wins over a software write-one-to-clear
    // ------------------------------------------------------------------
    logic write_collision_flag_ev;
    assign write_collision_flag_ev = wr_buf && busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_det_q <= 1'b0;
            irq_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            bcol_q <= 1'b0;
        end else begin
            if (stop_seen) begin
                stop_det_q <= 1'b1;
            end else if (wr_stat && pwdata[`IASS_STAT_STOPDET_BIT]) begin
                stop_det_q <= 1'b0;
            end
            if (done_stop || bcol_ev) begin
                irq_q <= 1'b1;
            end else if (wr_stat && pwdata[`IASS_STAT_IRQ_BIT]) begin
                irq_q <= 1'b0;
            end
            if (write_collision_flag_ev) begin
                write_collision_flag_q <= 1'b1;
            end else if (wr_stat && pwdata[`IASS_STAT_WRITE_COLLISION_FLAG_BIT]) begin
                write_collision_flag_q <= 1'b0;
            end
            if (bcol_ev) begin
                bcol_q <= 1'b1;
            end else if (wr_stat && pwdata[`IASS_STAT_BCOL_BIT]) begin
                bcol_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_q <= RW'(`IASS_RELOAD_RST);
            txbuf_q <= `IASS_TXBUF_RST;
        end else begin
            if (wr_en && paddr == `IASS_RELOAD_OFF) begin
                reload_q <= pwdata[RW-1:0];
            end
            if (wr_buf && !busy) begin
                txbuf_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        prdata = '0;
        if (rd_en) begin
            unique case (paddr)
                `IASS_CTRL_OFF: begin
                    prdata[`IASS_CTRL_ACK_SEQ_ENABLE_BIT] = ack_en_q;
                    prdata[`IASS_CTRL_STOPEN_BIT] = stop_en_q;
                    prdata[`IASS_CTRL_ACK_DATA_VALUE_BIT] = ack_dt_q;
                end
                `IASS_STAT_OFF: begin
                    prdata[`IASS_STAT_STOPDET_BIT] = stop_det_q;
                    prdata[`IASS_STAT_IRQ_BIT] = irq_q;
                    prdata[`IASS_STAT_WRITE_COLLISION_FLAG_BIT] = write_collision_flag_q;
                    prdata[`IASS_STAT_BCOL_BIT] = bcol_q;
                    prdata[`IASS_STAT_BUSY_BIT] = busy;
                end
                `IASS_RELOAD_OFF: begin
                    prdata[RW-1:0] = reload_q;
                end
                `IASS_TXBUF_OFF: begin
                    prdata[7:0] = txbuf_q;
                end
                default: begin
                    prdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_ack_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == IASS_IDLE && wr_ctrl && pwdata[`IASS_CTRL_ACK_SEQ_ENABLE_BIT])
        |=> bus_drive.clk_oe && ack_en_q;
    endproperty
    a_ack_start: assert property (p_ack_start)
        else $error("ack start did not pull clock low");

    property p_ack_data;
        @(posedge pclk) disable iff (!presetn)
        ack_en_q |-> (bus_drive.dat_oe == !ack_dt_q);
    endproperty
    a_ack_data: assert property (p_ack_data)
        else $error("ack data pin wrong");

    property p_ack_release;
        @(posedge pclk) disable iff (!presetn)
        (state_q == IASS_ACK_LOW && brg_tout) |=> !bus_drive.clk_oe;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("clock not released after period");

    property p_ack_end;
        @(posedge pclk) disable iff (!presetn)
        (state_q == IASS_ACK_HIGH && brg_tout)
        |=> !ack_en_q && !brg_run_q && state_q == IASS_IDLE;
    endproperty
    a_ack_end: assert property (p_ack_end)
        else $error("ack sequence did not end cleanly");

    property p_write_collision_flag;
        @(posedge pclk) disable iff (!presetn)
        write_collision_flag_ev |=> write_collision_flag_q && txbuf_q == $past(txbuf_q);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag)
        else $error("busy buffer write not dropped");

    property p_stop_low;
        @(posedge pclk) disable iff (!presetn)
        state_q == IASS_STP_DLOW |-> bus_drive.dat_oe && bus_drive.clk_oe;
    endproperty
    a_stop_low: assert property (p_stop_low)
        else $error("stop did not drive data low");

    property p_stop_reload;
        @(posedge pclk) disable iff (!presetn)
        (state_q == IASS_STP_WAIT_HI && clk_hi) |=> brg_q == reload_q;
    endproperty
    a_stop_reload: assert property (p_stop_reload)
        else $error("generator not reloaded");

    property p_stop_flag;
        @(posedge pclk) disable iff (!presetn)
        stop_seen |=> stop_det_q ##0 (stop_en_q)[*1];
    endproperty
    a_stop_flag: assert property (p_stop_flag)
        else $error("stop flag not set");

    property p_bcol;
        @(posedge pclk) disable iff (!presetn)
        bcol_ev |=> bcol_q && state_q == IASS_IDLE && !bus_drive.dat_oe;
    endproperty
    a_bcol: assert property (p_bcol)
        else $error("collision not handled");

endmodule

/* bench/iass_bus_model.sv */
// Far side of the two-wire bus: pull-ups, a slave that stretches the
// clock and a rival master that can hold either line low.
// Assumes open-drain drive from the sequencer, oe high pulls a line low.
module iass_bus_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire iass_pkg::iass_drive_t dut_drive,
    input wire logic [7:0] stretch_len,
    input wire logic hold_dat_low,
    input wire logic pull_clk_low,
    output iass_pkg::iass_sense_t sense
);
    timeunit 1ns;
    timeprecision 1ps;
    import iass_pkg::*;

    // ------------------------------------------------------------------
    // Clock stretching
    // ------------------------------------------------------------------
    logic clk_oe_q;
    logic [7:0] stretch_q;
    logic stretching;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_oe_q <= 1'b0;
            stretch_q <= 8'h00;
        end else begin
            clk_oe_q <= dut_drive.clk_oe;
            if (clk_oe_q && !dut_drive.clk_oe) begin
                stretch_q <= stretch_len;
            end else if (stretch_q != 8'h00) begin
                stretch_q <= stretch_q - 8'h01;
            end
        end
    end

    // Holds low from the very cycle of release, so no one-cycle glitch
    assign stretching = (stretch_q != 8'h00) ||
        (clk_oe_q && !dut_drive.clk_oe && stretch_len != 8'h00);

    // ------------------------------------------------------------------
    // Wired-AND lines, pulled up when nobody drives
    // ------------------------------------------------------------------
    assign sense = {!(dut_drive.clk_oe | pull_clk_low | stretching),
                    !(dut_drive.dat_oe | hold_dat_low)};
endmodule

/* bench/tb.sv */
// Self-checking bench for the acknowledge/stop sequencer.
// Assumes iass_bus_model on the bus side and APB with pready tied high.
`include "iass_params.svh"

module tb import iass_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } iass_row_t;

    localparam int RLD = 3;
    localparam int STR = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    iass_drive_t drv;
    iass_sense_t sns;
    logic [7:0] stretch_len;
    logic hold_dat_low, pull_clk_low, err;
    int error_cnt, comparisons, cycles, n;
    iass_row_t rows [10];

    iass_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_sense(sns), .bus_drive(drv));

    iass_bus_model far (.pclk(pclk), .presetn(presetn), .dut_drive(drv),
        .stretch_len(stretch_len), .hold_dat_low(hold_dat_low),
        .pull_clk_low(pull_clk_low), .sense(sns));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            stop_test;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic ok(input logic c, input string msg);
        comparisons++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // One idle edge before setup keeps two transfers off one time step
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cnt_hi(input logic dat, output int c);
        c = 0;
        while ((dat ? drv.dat_oe : drv.clk_oe) === 1'b1 && c < 300) begin
            @(posedge pclk);
            #1;
            c++;
        end
    endtask

    task automatic stop_test;
        $display("counts: %0d compared, %0d wrong", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, hold_dat_low, pull_clk_low} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        stretch_len = STR[7:0];
        presetn = 1'b0;
        rows[0] = '{1'b0, `IASS_CTRL_OFF, 32'h0, 32'h0, 1'b0};
        rows[1] = '{1'b0, `IASS_STAT_OFF, 32'h0, 32'h0, 1'b0};
        rows[2] = '{1'b0, `IASS_RELOAD_OFF, 32'h0,
                    {24'h0, `IASS_RELOAD_RST}, 1'b0};
        rows[3] = '{1'b0, `IASS_TXBUF_OFF, 32'h0, 32'h0, 1'b0};
        rows[4] = '{1'b1, `IASS_TXBUF_OFF, 32'ha5, 32'h0, 1'b0};
        rows[5] = '{1'b0, `IASS_TXBUF_OFF, 32'h0, 32'ha5, 1'b0};
        rows[6] = '{1'b1, `IASS_RELOAD_OFF, RLD, 32'h0, 1'b0};
        rows[7] = '{1'b0, `IASS_RELOAD_OFF, 32'h0, RLD, 1'b0};
        rows[8] = '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1};
        rows[9] = '{1'b1, 12'h010, 32'h5, 32'h0, 1'b1};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, err);
            ok(err === rows[i].err, "slave error");
            if (!rows[i].wr)
                ok(rd === rows[i].rdata, "read data");
        end
        $display("test registers done");

        for (int a = 0; a < 2; a++) begin
            apb(1'b1, `IASS_CTRL_OFF, {29'h0, a[0], 2'b01}, rd, err);
            #1;
            ok(drv.clk_oe === 1'b1, "ack clock low");
            ok(drv.dat_oe === ~a[0], "ack data level");
            cnt_hi(1'b0, n);
            ok(n == RLD + 1, "ack low phase");
            apb(1'b1, `IASS_TXBUF_OFF, 32'h3c, rd, err);
            repeat (4) @(posedge pclk);
            apb(1'b0, `IASS_STAT_OFF, 32'h0, rd, err);
            ok(rd[4] === 1'b1, "busy while stretched");
            repeat (20) @(posedge pclk);
            apb(1'b0, `IASS_CTRL_OFF, 32'h0, rd, err);
            ok(rd === {29'h0, a[0], 2'b00}, "ack enable");
            ok(drv.clk_oe === 1'b1, "clock held after ack");
            apb(1'b0, `IASS_STAT_OFF, 32'h0, rd, err);
            ok(rd === 32'h4, "ack status");
            apb(1'b0, `IASS_TXBUF_OFF, 32'h0, rd, err);
            ok(rd === 32'ha5, "buffer kept");
            apb(1'b1, `IASS_STAT_OFF, 32'h1f, rd, err);
        end
        $display("test acknowledge done");

        apb(1'b1, `IASS_CTRL_OFF, 32'h2, rd, err);
        #1;
        ok(drv.dat_oe === 1'b1, "stop data low");
        cnt_hi(1'b0, n);
        ok(n >= RLD + 1 && n <= RLD + 2, "stop clock phase");
        fork
            apb(1'b1, `IASS_TXBUF_OFF, 32'h77, rd, err);
            cnt_hi(1'b1, n);
        join
        ok(n - STR - RLD inside {[2:4]}, "release");
        apb(1'b0, `IASS_STAT_OFF, 32'h0, rd, err);
        ok(rd[1] === 1'b0 && rd[4] === 1'b1, "early irq");
        repeat (10) @(posedge pclk);
        apb(1'b0, `IASS_STAT_OFF, 32'h0, rd, err);
        ok(rd === 32'h7, "stop status");
        apb(1'b0, `IASS_CTRL_OFF, 32'h0, rd, err);
        ok(rd === 32'h0, "stop enable");
        apb(1'b0, `IASS_TXBUF_OFF, 32'h0, rd, err);
        ok(rd === 32'ha5, "buffer kept");
        apb(1'b1, `IASS_STAT_OFF, 32'h1f, rd, err);
        $display("test stop done");

        // Both collision cases run without stretching
        stretch_len <= 8'h00;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `IASS_CTRL_OFF, 32'h2, rd, err);
            #1;
            cnt_hi(1'b0, n);
            if (k == 0)
                cnt_hi(1'b1, n);
            @(posedge pclk);
            hold_dat_low <= (k == 0);
            pull_clk_low <= (k == 1);
            repeat (12) @(posedge pclk);
            #1;
            ok(drv === 2'b00, "lines released");
            apb(1'b0, `IASS_STAT_OFF, 32'h0, rd, err);
            ok(rd === 32'ha, "bcol status");
            apb(1'b0, `IASS_CTRL_OFF, 32'h0, rd, err);
            ok(rd === 32'h0, "back to idle");
            hold_dat_low <= 1'b0;
            pull_clk_low <= 1'b0;
            apb(1'b1, `IASS_STAT_OFF, 32'h1f, rd, err);
        end
        $display("test collision done");

        apb(1'b1, `IASS_CTRL_OFF, 32'h1, rd, err);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        ok(drv === 2'b00, "released in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `IASS_RELOAD_OFF, 32'h0, rd, err);
        ok(rd === {24'h0, `IASS_RELOAD_RST}, "reload after reset");
        apb(1'b0, `IASS_CTRL_OFF, 32'h0, rd, err);
        ok(rd === 32'h0, "control after reset");
        $display("test reset done");
        stop_test;
    end
endmodule
